// *** rtl/esb_core.sv ***
// edge-triggered shift bit: synchronised inputs, priority logic, retained output
`timescale 1ns/1ns

module esb_core
  import esb_pkg::*;
(
  // clock and resets
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic por_i,
  // operating mode from the controller
  input  wire logic run_i,
  // function block inputs
  input  wire logic data_i,
  input  wire logic trig_i,
  input  wire logic set_i,
  input  wire logic clr_i,
  // function block output and status
  output logic      q_o,
  output logic      active_o
);

  // ---------------------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------------------
  logic [IN_COUNT-1:0] sync_a;
  logic [IN_COUNT-1:0] sync_b;
  logic                trig_prev;
  logic [1:0]          prime_cnt;
  esb_state_t          state;
  esb_state_t          next_state;
  logic                data_s;
  logic                trig_s;
  logic                set_s;
  logic                clr_s;
  logic                rise;
  logic                next_q;
  logic                store_we;

  // ---------------------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------------------
  // the inputs come from other blocks or pins of unknown timing, so all four
  // pass two flops; they share one stage so their relative timing is kept
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_a <= SYNC_RESET;
      sync_b <= SYNC_RESET;
    end else begin
      sync_a <= {clr_i, set_i, trig_i, data_i};
      sync_b <= sync_a;
    end
  end

  assign data_s = sync_b[IDX_DATA];
  assign trig_s = sync_b[IDX_TRIG];
  assign set_s  = sync_b[IDX_SET];
  assign clr_s  = sync_b[IDX_CLR];

  // ---------------------------------------------------------------------------
  // edge detection
  // ---------------------------------------------------------------------------
  // previous trigger level, updated every cycle outside reset so a level held through a stop
  // is not mistaken for a fresh edge; reset clears it, and prime hides the edge seen after reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trig_prev <= PREV_RESET;
    end else begin
      trig_prev <= trig_s;
    end
  end

  assign rise = trig_s & ~trig_prev;

  // ---------------------------------------------------------------------------
  // operating state
  // ---------------------------------------------------------------------------
  // prime gives the synchronisers and edge history time to refill after reset
  // or stop; an edge that happens while stopped is lost, as in a halted scan
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        next_state = ST_PRIME;
      end
      ST_PRIME: begin
        if (prime_cnt == PRIME_CYCLES - PRIME_STEP) begin
          next_state = run_i ? ST_RUN : ST_STOP;
        end
      end
      ST_RUN: begin
        if (!run_i) begin
          next_state = ST_STOP;
        end
      end
      ST_STOP: begin
        if (run_i) begin
          next_state = ST_PRIME;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // prime counter, restarted whenever prime is entered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prime_cnt <= PRIME_RESET;
    end else if (state != ST_PRIME) begin
      prime_cnt <= PRIME_RESET;
    end else begin
      prime_cnt <= prime_cnt + PRIME_STEP;
    end
  end

  assign active_o = (state == ST_RUN);

  // ---------------------------------------------------------------------------
  // priority resolution
  // ---------------------------------------------------------------------------
  // set beats reset beats shift with no request the output holds, which is
  // what keeps data changes between edges from reaching the output
  always_comb begin
    if (set_s) begin
      next_q = 1'h1;
    end else if (clr_s) begin
      next_q = 1'h0;
    end else if (rise) begin
      next_q = data_s;
    end else begin
      next_q = q_o;
    end
  end

  // writes only while running; reset and stop leave the retained bit as is
  assign store_we = (state == ST_RUN) & ~rst_i;

  // ---------------------------------------------------------------------------
  // retained output storage
  // ---------------------------------------------------------------------------
  esb_retain u_retain (
    .clk_i (clk_i),
    .por_i (por_i),
    .we_i  (store_we),
    .d_i   (next_q),
    .q_o   (q_o)
  );

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  chk_edge_capture: assert property (
    @(posedge clk_i) disable iff (rst_i || por_i)
    (state == ST_RUN && rise && !set_s && !clr_s) |=> (q_o == $past(data_s)))
    else $error("output did not take data bit on trigger edge");

  chk_hold_between: assert property (
    @(posedge clk_i) disable iff (rst_i || por_i)
    (state == ST_RUN && !rise && !set_s && !clr_s) |=> $stable(q_o))
    else $error("output changed without edge, set or reset");

  chk_set_forces: assert property (
    @(posedge clk_i) disable iff (rst_i || por_i)
    (state == ST_RUN && set_s) |=> q_o)
    else $error("set did not drive output on");

  chk_reset_forces: assert property (
    @(posedge clk_i) disable iff (rst_i || por_i)
    (state == ST_RUN && clr_s && !set_s) |=> !q_o)
    else $error("reset did not drive output off");

  chk_set_over_reset: assert property (
    @(posedge clk_i) disable iff (rst_i || por_i)
    (state == ST_RUN && set_s && clr_s && rise && !data_s) |=> q_o)
    else $error("set lost against reset or shift");

  chk_reset_over_shift: assert property (
    @(posedge clk_i) disable iff (rst_i || por_i)
    (state == ST_RUN && clr_s && !set_s && rise && data_s) |=> !q_o)
    else $error("reset lost against shift");

  chk_warm_retain: assert property (
    @(posedge clk_i) disable iff (por_i)
    (rst_i && !por_i) |=> (q_o == $past(q_o)))
    else $error("warm reset disturbed retained output");

  chk_cold_start: assert property (
    @(posedge clk_i)
    por_i |=> !q_o)
    else $error("cold start did not clear output");

  chk_pin_latency: assert property (
    @(posedge clk_i) disable iff (rst_i || por_i)
    (set_i && state == ST_RUN) ##1 (state == ST_RUN) ##1 (state == ST_RUN) |=> q_o)
    else $error("set pin not seen at output within three cycles");

  chk_stop_hold: assert property (
    @(posedge clk_i) disable iff (rst_i || por_i)
    (state == ST_STOP) |=> $stable(q_o))
    else $error("output changed while stopped");

endmodule

// *** rtl/esb_pkg.sv ***
// shared constants and types for the edge-triggered shift bit
package esb_pkg;

  // ---------------------------------------------------------------------------
  // input bundle indices
  // ---------------------------------------------------------------------------
  localparam int unsigned IN_COUNT = 4;
  localparam int unsigned IDX_DATA = 0;
  localparam int unsigned IDX_TRIG = 1;
  localparam int unsigned IDX_SET  = 2;
  localparam int unsigned IDX_CLR  = 3;

  // ---------------------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------------------
  localparam logic [3:0] SYNC_RESET  = 4'h0;
  localparam logic       OUT_RESET   = 1'h0;
  localparam logic       PREV_RESET  = 1'h0;

  // ---------------------------------------------------------------------------
  // timing counts
  // ---------------------------------------------------------------------------
  // cycles spent refilling the synchronisers and the edge history after reset
  localparam logic [1:0] PRIME_CYCLES = 2'h3;
  localparam logic [1:0] PRIME_RESET  = 2'h0;
  localparam logic [1:0] PRIME_STEP   = 2'h1;

  // ---------------------------------------------------------------------------
  // operating states
  // ---------------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_PRIME = 4'h2,
    ST_RUN   = 4'h4,
    ST_STOP  = 4'h8
  } esb_state_t;

endpackage

// *** rtl/esb_retain.sv ***
// retentive storage cell holding the shift bit across warm restarts
`timescale 1ns/1ns

module esb_retain
  import esb_pkg::*;
(
  // clock and cold start
  input  wire logic clk_i,
  input  wire logic por_i,
  // write side
  input  wire logic we_i,
  input  wire logic d_i,
  // stored bit
  output logic      q_o
);

  // ---------------------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------------------
  // only the cold start clears this cell; the warm reset leaves it alone so
  // the last output survives a power cycle of the program logic
  always_ff @(posedge clk_i) begin
    if (por_i) begin
      q_o <= OUT_RESET;
    end else if (we_i) begin
      q_o <= d_i;
    end
  end

endmodule

// *** test/esb_src.sv ***
// far-side model: other program blocks driving the shift bit inputs
`timescale 1ns/1ns

module esb_src (
  // clock
  input  wire logic clk_i,
  // function block inputs
  output logic      data_o,
  output logic      trig_o,
  output logic      set_o,
  output logic      clr_o
);
  // ---------------------------------------------------------------------------
  // levels
  // ---------------------------------------------------------------------------
  // start OFF so a cold start sees no trigger edge
  initial begin
    data_o = 1'h0;
    trig_o = 1'h0;
    set_o  = 1'h0;
    clr_o  = 1'h0;
  end

  // all four levels change together just after a clock edge
  task automatic drive(input logic d, input logic t, input logic s, input logic c);
    @(posedge clk_i);
    data_o <= d;
    trig_o <= t;
    set_o  <= s;
    clr_o  <= c;
  endtask
endmodule

// *** test/test_edge_triggered_shift_bit.sv ***
// self-checking bench for the edge-triggered shift bit core
`timescale 1ns/1ns

module test_edge_triggered_shift_bit;
  import esb_pkg::*;

  // ---------------------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------------------
  logic clk_i;
  logic rst_i;
  logic por_i;
  logic run_i;
  logic data, trig, set, clr;
  logic q_o;
  logic active_o;
  int   n_fail;
  int   num_checks;

  esb_src i_esb_src (.clk_i(clk_i), .data_o(data), .trig_o(trig), .set_o(set), .clr_o(clr));

  esb_core i_esb_core (
    .clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .run_i(run_i),
    .data_i(data), .trig_i(trig), .set_i(set), .clr_i(clr),
    .q_o(q_o), .active_o(active_o)
  );

  // 50 MHz clock
  initial begin
    clk_i = 1'h0;
    forever #10 clk_i = ~clk_i;
  end

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  task automatic check(input string nm, input logic exp, input logic seen);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %b seen %b", nm, exp, seen);
    end
  endtask

  // sync (2) plus output flop: four edges leave margin past the answer
  task automatic settle();
    repeat (4) @(posedge clk_i);
    #1;
  endtask

  // bounded wait for run state after a cold start, a warm reset or a stop
  task automatic wait_run();
    int n;
    n = 0;
    while (active_o !== 1'h1 && n < 20) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    check("active_o", 1'h1, active_o);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  // capture on rising edges only; data moves between edges are ignored
  task automatic t_shift();
    i_esb_src.drive(1'h1, 1'h0, 1'h0, 1'h0);
    i_esb_src.drive(1'h1, 1'h1, 1'h0, 1'h0);
    settle();
    check("shift one", 1'h1, q_o);
    i_esb_src.drive(1'h0, 1'h0, 1'h0, 1'h0);
    settle();
    check("hold low trig", 1'h1, q_o);
    i_esb_src.drive(1'h0, 1'h1, 1'h0, 1'h0);
    settle();
    check("shift zero", 1'h0, q_o);
    i_esb_src.drive(1'h1, 1'h1, 1'h0, 1'h0);
    settle();
    check("hold high trig", 1'h0, q_o);
  endtask

  // set beats reset beats shift, back to back
  task automatic t_force();
    i_esb_src.drive(1'h0, 1'h0, 1'h1, 1'h0);
    settle();
    check("set only", 1'h1, q_o);
    i_esb_src.drive(1'h0, 1'h1, 1'h1, 1'h1);
    settle();
    check("set and clr", 1'h1, q_o);
    i_esb_src.drive(1'h0, 1'h0, 1'h0, 1'h1);
    settle();
    check("clr only", 1'h0, q_o);
    i_esb_src.drive(1'h1, 1'h1, 1'h0, 1'h1);
    settle();
    check("clr over edge", 1'h0, q_o);
    i_esb_src.drive(1'h1, 1'h0, 1'h0, 1'h0);
    settle();
  endtask

  // warm restart keeps q; a trigger raised during reset is no edge
  task automatic t_retain();
    i_esb_src.drive(1'h0, 1'h0, 1'h1, 1'h0);
    i_esb_src.drive(1'h0, 1'h0, 1'h0, 1'h0);
    settle();
    @(posedge clk_i);
    rst_i <= 1'h1;
    i_esb_src.drive(1'h0, 1'h1, 1'h0, 1'h0);
    settle();
    check("q in reset", 1'h1, q_o);
    check("active_o in reset", 1'h0, active_o);
    @(posedge clk_i);
    rst_i <= 1'h0;
    wait_run();
    settle();
    check("q after reset", 1'h1, q_o);
  endtask

  // stop freezes q: a reset pulse while stopped is lost; run resumes via prime
  task automatic t_stop();
    @(posedge clk_i);
    run_i <= 1'h0;
    settle();
    check("active_o stop", 1'h0, active_o);
    i_esb_src.drive(1'h0, 1'h1, 1'h0, 1'h1);
    i_esb_src.drive(1'h0, 1'h1, 1'h0, 1'h0);
    settle();
    check("q in stop", 1'h1, q_o);
    @(posedge clk_i);
    run_i <= 1'h1;
    wait_run();
    settle();
    check("q after stop", 1'h1, q_o);
    i_esb_src.drive(1'h0, 1'h1, 1'h0, 1'h1);
    settle();
    check("clr after stop", 1'h0, q_o);
    i_esb_src.drive(1'h0, 1'h1, 1'h0, 1'h0);
    settle();
  endtask

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    rst_i      = 1'h1;
    por_i      = 1'h1;
    run_i      = 1'h1;
    n_fail     = 0;
    num_checks = 0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'h0;
    por_i <= 1'h0;
    wait_run();
    check("cold start q", 1'h0, q_o);
    t_shift();
    t_force();
    t_retain();
    t_stop();
    close_out();
  end

  // watchdog: the sequence needs well under 300 cycles
  initial begin
    repeat (2000) @(posedge clk_i);
    n_fail++;
    close_out();
  end
endmodule
